/* File: ffw_pkg.sv */
// Shared constants and types of the frame forwarding filter.
// Assumes a single system clock; no other package is needed.
package ffw_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NPORTS = 24;
  localparam int PW = 5;
  localparam int NVLAN = 4;
  localparam int DUMP_FW = 8;
  localparam logic [PW-1:0] CPU_PORT = 5'h17;
  localparam logic [PW-1:0] LAST_PORT = 5'h17;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_VLAN0 = 8'h04;
  localparam logic [7:0] ADDR_DUMP = 8'h14;
  localparam logic [7:0] ADDR_BLOCK = 8'h18;
  localparam logic [7:0] ADDR_STPPORT = 8'h1c;
  localparam logic [7:0] ADDR_DUPLEX = 8'h20;
  localparam logic [7:0] ADDR_FCTRL = 8'h24;
  localparam logic [7:0] ADDR_FRAMES = 8'h28;
  localparam logic [7:0] ADDR_DROPS = 8'h2c;
  localparam logic [7:0] VLAN_STRIDE = 8'h04;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_STP_BIT = 1;
  localparam int CFG_FLOOD_BIT = 12;
  localparam int FCTRL_BP_BIT = 0;
  localparam int FCTRL_PAUSE_BIT = 1;
  localparam logic [23:0] VLAN0_RST = 24'hff_ffff;
  localparam logic [23:0] MASK_RST = 24'h00_0000;
  localparam logic [31:0] DUMP_RST = 32'h0000_0000;
  localparam logic [31:0] FCTRL_RST = 32'h0000_0003;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DA_UCAST, DA_MCAST, DA_BCAST, DA_BPDU, DA_PAUSE
  } ffw_da_t;

  typedef enum logic {ENQ_IDLE, ENQ_WALK} ffw_enq_t;

endpackage : ffw_pkg

/* File: ffw_queue_mem.sv */
// Simple dual-port store holding the per-port transmit queue entries.
// Assumes one clock; read data appear one edge after the read address.
`timescale 1ns/1ps
module ffw_queue_mem #(
  parameter int W = 17,
  parameter int AW = 9
) (
  // Clock
  input wire logic clock,
  input wire logic reset_n,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  // Read port
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [W-1:0] rdData
);

  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : ffw_queue_mem

/* File: ffw_duplex_ctrl.sv */
// Per-port duplex mode and flow control method selection.
// Assumes congestion flags come from the queue manager on the same clock.
`timescale 1ns/1ps
module ffw_duplex_ctrl #(
  parameter int N = 24
) (
  // Clock
  input wire logic clock,
  input wire logic reset_n,
  // Configuration
  input wire logic [N-1:0] fullDuplex,
  input wire logic bpEnable,
  input wire logic pauseEnable,
  // Congestion per port
  input wire logic [N-1:0] congest,
  // Per-port controls to the MACs
  output logic [N-1:0] csmaEn,
  output logic [N-1:0] jamReq,
  output logic [N-1:0] pauseReq
);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      csmaEn <= '0;
      jamReq <= '0;
      pauseReq <= '0;
    end else begin
      csmaEn <= ~fullDuplex;
      jamReq <= congest & ~fullDuplex & {N{bpEnable}};
      pauseReq <= congest & fullDuplex & {N{pauseEnable}};
    end
  end

endmodule : ffw_duplex_ctrl

/* File: ffw_forward_filter.sv */
// Forwarding decision, egress filter and per-port transmit queues.
// Assumes frame descriptors and dequeue requests on the system clock,
// and an APB master for the configuration registers.
//
// Function
// - Flooding off: unknown unicast goes to the source VLAN dumping port.
// - Unicast matching no port in the source VLAN goes to dumping port; with flood-all set it goes to all VLAN ports but source.
// - Broadcast and multicast also reach the dumping port.
// - Flood-all bit set: unknown DA goes to all VLAN ports but source.
// - Half duplex ports use CSMA/CD and backpressure.
// - Full duplex ports run independently and use pause frames.
// - Spanning tree on: BPDU from CPU port goes to CPU-chosen port.
// - Spanning tree on: BPDU from other ports goes to CPU if VLAN shared.
// - Port 23 is the CPU port.
// - Spanning tree off: BPDU treated as broadcast, pause frames excepted.
// - Each port can be set to block-and-listen by a register.
// - Blocked port: received BPDU to CPU, all else discarded.
// - Blocked port: only BPDU frames are transmitted, others filtered.
// - Each frame is enqueued on the queue of every destination port; a full queue drops it instead and counts it in drops_r.
// - Arrival order is kept within each destination queue.
// - Known unicast forwarded only if destination shares a VLAN.
// - Broadcast and multicast reach all ports of source VLANs; the code leaves out the source port.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ffw_forward_filter #(
  parameter int HW = 16,
  parameter int QDEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame descriptor in
  input wire logic frmValid,
  output logic frmReady,
  input wire logic [ffw_pkg::PW-1:0] frmSrcPort,
  input wire ffw_pkg::ffw_da_t frmDaClass,
  input wire logic frmDstKnown,
  input wire logic [ffw_pkg::PW-1:0] frmDstPort,
  input wire logic [HW-1:0] frmHandle,
  // Forwarding decision out
  output logic fwdValid,
  output logic [ffw_pkg::NPORTS-1:0] fwdMask,
  output logic [HW-1:0] fwdHandle,
  // Transmit queue dequeue
  input wire logic deqReq,
  input wire logic [ffw_pkg::PW-1:0] deqPort,
  output logic deqValid,
  output logic deqEmpty,
  output logic deqDrop,
  output logic [HW-1:0] deqHandle,
  // Flow control
  input wire logic [ffw_pkg::NPORTS-1:0] congest,
  output logic [ffw_pkg::NPORTS-1:0] csmaEn,
  output logic [ffw_pkg::NPORTS-1:0] jamReq,
  output logic [ffw_pkg::NPORTS-1:0] pauseReq
);

  localparam int N = ffw_pkg::NPORTS;
  localparam int PW = ffw_pkg::PW;
  localparam int QAW = $clog2(QDEPTH);
  localparam int MAW = PW + QAW;
  localparam logic [QAW:0] QFULL = (QAW+1)'(QDEPTH);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [N-1:0] onehot(input logic [PW-1:0] p);
    logic [N-1:0] m;
    m = '0;
    for (int i = 0; i < N; i++) begin
      if (p == PW'(i)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : onehot

  function automatic logic inMask(input logic [N-1:0] m,
                                  input logic [PW-1:0] p);
    return |(m & onehot(p));
  endfunction : inMask

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic stpEn_r;
  logic floodAll_r;
  logic [N-1:0] vlanMem_r [ffw_pkg::NVLAN];
  logic [31:0] dump_r;
  logic [N-1:0] blockListen_r;
  logic [PW-1:0] stpPortSel_r;
  logic [N-1:0] fullDuplex_r;
  logic bpEn_r;
  logic pauseEn_r;
  logic [31:0] frames_r;
  logic [31:0] drops_r;

  logic apbAcc;
  logic wrEn;
  assign apbAcc = psel & penable;
  assign wrEn = apbAcc & pready & pwrite;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= ffw_pkg::ADDR_DROPS;
  endfunction : mapped

  function automatic logic [7:0] vlanAddr(input int v);
    return 8'(ffw_pkg::ADDR_VLAN0 + 8'(v) * ffw_pkg::VLAN_STRIDE);
  endfunction : vlanAddr

  function automatic logic [PW-1:0] dumpPort(input logic [31:0] d,
                                             input int v);
    return d[v*ffw_pkg::DUMP_FW +: PW];
  endfunction : dumpPort

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stpEn_r <= 1'b0;
      floodAll_r <= 1'b0;
      dump_r <= ffw_pkg::DUMP_RST;
      blockListen_r <= ffw_pkg::MASK_RST;
      stpPortSel_r <= '0;
      fullDuplex_r <= ffw_pkg::MASK_RST;
      bpEn_r <= ffw_pkg::FCTRL_RST[ffw_pkg::FCTRL_BP_BIT];
      pauseEn_r <= ffw_pkg::FCTRL_RST[ffw_pkg::FCTRL_PAUSE_BIT];
    end else if (wrEn) begin
      unique case (paddr)
        ffw_pkg::ADDR_CFG: begin
          stpEn_r <= pwdata[ffw_pkg::CFG_STP_BIT];
          floodAll_r <= pwdata[ffw_pkg::CFG_FLOOD_BIT];
        end
        ffw_pkg::ADDR_DUMP: dump_r <= pwdata;
        ffw_pkg::ADDR_BLOCK: blockListen_r <= pwdata[N-1:0];
        ffw_pkg::ADDR_STPPORT: stpPortSel_r <= pwdata[PW-1:0];
        ffw_pkg::ADDR_DUPLEX: fullDuplex_r <= pwdata[N-1:0];
        ffw_pkg::ADDR_FCTRL: begin
          bpEn_r <= pwdata[ffw_pkg::FCTRL_BP_BIT];
          pauseEn_r <= pwdata[ffw_pkg::FCTRL_PAUSE_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int v = 0; v < ffw_pkg::NVLAN; v++) begin
        vlanMem_r[v] <= (v == 0) ? ffw_pkg::VLAN0_RST : ffw_pkg::MASK_RST;
      end
    end else if (wrEn) begin
      for (int v = 0; v < ffw_pkg::NVLAN; v++) begin
        if (paddr == vlanAddr(v)) begin
          vlanMem_r[v] <= pwdata[N-1:0];
        end
      end
    end
  end

  function automatic logic [31:0] regRead(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      ffw_pkg::ADDR_CFG: begin
        r[ffw_pkg::CFG_STP_BIT] = stpEn_r;
        r[ffw_pkg::CFG_FLOOD_BIT] = floodAll_r;
      end
      ffw_pkg::ADDR_DUMP: r = dump_r;
      ffw_pkg::ADDR_BLOCK: r[N-1:0] = blockListen_r;
      ffw_pkg::ADDR_STPPORT: r[PW-1:0] = stpPortSel_r;
      ffw_pkg::ADDR_DUPLEX: r[N-1:0] = fullDuplex_r;
      ffw_pkg::ADDR_FCTRL: begin
        r[ffw_pkg::FCTRL_BP_BIT] = bpEn_r;
        r[ffw_pkg::FCTRL_PAUSE_BIT] = pauseEn_r;
      end
      ffw_pkg::ADDR_FRAMES: r = frames_r;
      ffw_pkg::ADDR_DROPS: r = drops_r;
      default: begin
        for (int v = 0; v < ffw_pkg::NVLAN; v++) begin
          if (a == vlanAddr(v)) begin
            r[N-1:0] = vlanMem_r[v];
          end
        end
      end
    endcase
    return r;
  endfunction : regRead

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAcc & ~pready;
      if (apbAcc & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : regRead(paddr);
        pslverr <= ~mapped(paddr);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------------
  logic [N-1:0] decMask;
  logic [N-1:0] domain;
  logic [N-1:0] dumpMask;
  logic [N-1:0] srcBit;
  logic [N-1:0] cpuBit;

  always_comb begin
    domain = '0;
    dumpMask = '0;
    srcBit = onehot(frmSrcPort);
    cpuBit = onehot(ffw_pkg::CPU_PORT);
    for (int v = 0; v < ffw_pkg::NVLAN; v++) begin
      if (inMask(vlanMem_r[v], frmSrcPort)) begin
        domain = domain | vlanMem_r[v];
        dumpMask = dumpMask | onehot(dumpPort(dump_r, v));
      end
    end
    if (inMask(blockListen_r, frmSrcPort)) begin
      decMask = (frmDaClass == ffw_pkg::DA_BPDU) ? cpuBit : '0;
    end else if (frmDaClass == ffw_pkg::DA_PAUSE) begin
      decMask = '0;
    end else if (frmDaClass == ffw_pkg::DA_BPDU && stpEn_r) begin
      if (frmSrcPort == ffw_pkg::CPU_PORT) begin
        decMask = onehot(stpPortSel_r);
      end else begin
        decMask = inMask(domain, ffw_pkg::CPU_PORT) ? cpuBit : '0;
      end
    end else if (frmDaClass != ffw_pkg::DA_UCAST) begin
      // Broadcast, multicast, and BPDU with spanning tree off
      decMask = (domain | dumpMask) & ~srcBit;
    end else if (frmDstKnown && inMask(domain, frmDstPort)
                 && frmDstPort != frmSrcPort) begin
      decMask = onehot(frmDstPort);
    end else if (floodAll_r) begin
      decMask = domain & ~srcBit;
    end else begin
      decMask = dumpMask & ~srcBit;
    end
  end

  // ----------------------------------------------------------------------
  // Enqueue walk over destination ports
  // ----------------------------------------------------------------------
  ffw_pkg::ffw_enq_t enqState_r;
  logic [PW-1:0] walkIdx_r;
  logic walkBpdu_r;
  logic [QAW:0] head_r [N];
  logic [QAW:0] tail_r [N];
  logic walkHit;
  logic walkFull;
  logic enqWr;
  logic frmTake;

  assign frmTake = frmValid & frmReady;
  assign walkHit = enqState_r == ffw_pkg::ENQ_WALK
                   && inMask(fwdMask, walkIdx_r);
  assign walkFull = (tail_r[walkIdx_r] - head_r[walkIdx_r]) == QFULL;
  assign enqWr = walkHit & ~walkFull;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enqState_r <= ffw_pkg::ENQ_IDLE;
      walkIdx_r <= '0;
      frmReady <= 1'b0;
    end else begin
      unique case (enqState_r)
        ffw_pkg::ENQ_IDLE: begin
          frmReady <= ~frmTake;
          walkIdx_r <= '0;
          if (frmTake) begin
            enqState_r <= ffw_pkg::ENQ_WALK;
          end
        end
        ffw_pkg::ENQ_WALK: begin
          walkIdx_r <= walkIdx_r + 1'b1;
          if (walkIdx_r == ffw_pkg::LAST_PORT) begin
            enqState_r <= ffw_pkg::ENQ_IDLE;
            frmReady <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fwdValid <= 1'b0;
      fwdMask <= '0;
      fwdHandle <= '0;
      walkBpdu_r <= 1'b0;
    end else begin
      fwdValid <= frmTake;
      if (frmTake) begin
        fwdMask <= decMask;
        fwdHandle <= frmHandle;
        walkBpdu_r <= frmDaClass == ffw_pkg::DA_BPDU;
      end
    end
  end

  // Tail only advances in port order, one frame at a time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        tail_r[i] <= '0;
      end
    end else if (enqWr) begin
      tail_r[walkIdx_r] <= tail_r[walkIdx_r] + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frames_r <= '0;
      drops_r <= '0;
    end else begin
      if (frmTake) begin
        frames_r <= frames_r + 1'b1;
      end
      if (walkHit & walkFull) begin
        drops_r <= drops_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Dequeue and egress filter
  // ----------------------------------------------------------------------
  logic deqNonEmpty;
  logic deqP1_r;
  logic deqP1Empty_r;
  logic [PW-1:0] deqP1Port_r;
  logic [HW:0] rdData;

  assign deqNonEmpty = deqReq && tail_r[deqPort] != head_r[deqPort];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        head_r[i] <= '0;
      end
    end else if (deqNonEmpty) begin
      head_r[deqPort] <= head_r[deqPort] + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      deqP1_r <= 1'b0;
      deqP1Empty_r <= 1'b0;
      deqP1Port_r <= '0;
      deqValid <= 1'b0;
      deqEmpty <= 1'b0;
      deqDrop <= 1'b0;
      deqHandle <= '0;
    end else begin
      deqP1_r <= deqReq;
      deqP1Empty_r <= ~deqNonEmpty;
      deqP1Port_r <= deqPort;
      deqValid <= deqP1_r;
      deqEmpty <= deqP1_r & deqP1Empty_r;
      deqHandle <= rdData[HW-1:0];
      deqDrop <= deqP1_r & ~deqP1Empty_r & ~rdData[HW]
                 & inMask(blockListen_r, deqP1Port_r);
    end
  end

  ffw_queue_mem #(
    .W(HW + 1),
    .AW(MAW)
  ) u_mem (
    .clock(clock),
    .reset_n(reset_n),
    .wrEn(enqWr),
    .wrAddr({walkIdx_r, tail_r[walkIdx_r][QAW-1:0]}),
    .wrData({walkBpdu_r, fwdHandle}),
    .rdEn(deqNonEmpty),
    .rdAddr({deqPort, head_r[deqPort][QAW-1:0]}),
    .rdData(rdData)
  );

  // ----------------------------------------------------------------------
  // Duplex and flow control
  // ----------------------------------------------------------------------
  ffw_duplex_ctrl #(
    .N(N)
  ) u_duplex (
    .clock(clock),
    .reset_n(reset_n),
    .fullDuplex(fullDuplex_r),
    .bpEnable(bpEn_r),
    .pauseEnable(pauseEn_r),
    .congest(congest),
    .csmaEn(csmaEn),
    .jamReq(jamReq),
    .pauseReq(pauseReq)
  );

endmodule : ffw_forward_filter

/* File: ffw_forward_filter_sva.sv */
// Concurrent checks on the port behaviour of the forwarding filter.
// Bound to every ffw_forward_filter instance; one clock domain.
`timescale 1ns/1ps
module ffw_forward_filter_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Frames
  input wire logic frmValid,
  input wire logic frmReady,
  input wire logic [ffw_pkg::PW-1:0] frmSrcPort,
  input wire ffw_pkg::ffw_da_t frmDaClass,
  input wire logic fwdValid,
  input wire logic [ffw_pkg::NPORTS-1:0] fwdMask,
  // Queues and flow control
  input wire logic deqReq,
  input wire logic deqValid,
  input wire logic [ffw_pkg::NPORTS-1:0] congest,
  input wire logic [ffw_pkg::NPORTS-1:0] csmaEn,
  input wire logic [ffw_pkg::NPORTS-1:0] jamReq,
  input wire logic [ffw_pkg::NPORTS-1:0] pauseReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_apb_one_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("APB answer not in second access cycle");
  a_apb_pulse: assert property (
    pready |=> !pready)
    else $error("APB ready longer than one cycle");
  a_apb_err_map: assert property (
    psel && pready |-> pslverr ==
      (paddr > ffw_pkg::ADDR_DROPS || paddr[1:0] != 2'b00))
    else $error("APB error flag wrong for address");
  a_fwd_after_take: assert property (
    frmValid && frmReady |=> fwdValid ##1 (!fwdValid && !frmReady)[*8])
    else $error("Decision pulse or busy window wrong");
  a_src_bit_clear: assert property (
    fwdValid && $past(frmDaClass) != ffw_pkg::DA_BPDU
      |-> !fwdMask[$past(frmSrcPort)])
    else $error("Source port present in decision mask");
  a_pause_no_dest: assert property (
    fwdValid && $past(frmDaClass) == ffw_pkg::DA_PAUSE |-> fwdMask == '0)
    else $error("Pause frame was forwarded");
  a_deq_latency: assert property (
    deqReq |-> ##2 deqValid)
    else $error("Dequeue answer not two cycles after request");
  a_deq_no_spur: assert property (
    deqValid |-> $past(deqReq, 2))
    else $error("Dequeue answer without request");
  a_jam_half_only: assert property (
    jamReq != '0 |-> (jamReq & ~csmaEn) == '0
      && (jamReq & ~$past(congest)) == '0)
    else $error("Jam on full duplex or idle port");
  a_pause_full_only: assert property (
    pauseReq != '0 |-> (pauseReq & csmaEn) == '0
      && (pauseReq & ~$past(congest)) == '0)
    else $error("Pause on half duplex or idle port");
endmodule : ffw_forward_filter_sva

bind ffw_forward_filter ffw_forward_filter_sva sva_u (.clock, .reset_n,
  .paddr, .psel, .penable, .pready, .pslverr, .frmValid, .frmReady,
  .frmSrcPort, .frmDaClass, .fwdValid, .fwdMask, .deqReq, .deqValid,
  .congest, .csmaEn, .jamReq, .pauseReq);

/* File: ffw_port_partner.sv */
// Model of the port MACs and queue manager: offers frame descriptors
// and pops transmit queues. Tasks are entered just after a rising edge.
`timescale 1ns/1ps
module ffw_port_partner (
  // Clock
  input wire logic clock,
  // Descriptor side
  output logic frmValid,
  input wire logic frmReady,
  output logic [4:0] frmSrcPort,
  output ffw_pkg::ffw_da_t frmDaClass,
  output logic frmDstKnown,
  output logic [4:0] frmDstPort,
  output logic [15:0] frmHandle,
  input wire logic fwdValid,
  input wire logic [23:0] fwdMask,
  // Dequeue side
  output logic deqReq,
  output logic [4:0] deqPort,
  input wire logic deqValid,
  input wire logic deqEmpty,
  input wire logic deqDrop,
  input wire logic [15:0] deqHandle
);
  initial begin
    {frmValid, frmSrcPort, frmDstKnown, frmDstPort, frmHandle, deqReq,
      deqPort} = '0;
    frmDaClass = ffw_pkg::DA_UCAST;
  end

  // Descriptor held until the edge that takes it; returns {valid, mask}
  task automatic sendFrame(input logic [4:0] src, input ffw_pkg::ffw_da_t cls,
      input logic known, input logic [4:0] dst, input logic [15:0] h,
      output logic [24:0] res);
    logic ok;
    frmValid <= 1'b1;
    frmSrcPort <= src;
    frmDaClass <= cls;
    frmDstKnown <= known;
    frmDstPort <= dst;
    frmHandle <= h;
    do begin
      @(negedge clock);
      ok = frmReady;
      @(posedge clock);
    end while (!ok);
    frmValid <= 1'b0;
    @(negedge clock);
    res = {fwdValid, fwdMask};
    @(posedge clock);
  endtask : sendFrame

  // Waits for the port walk to end, then pops; returns {empty, drop, h}
  task automatic popQueue(input logic [4:0] p, output logic [17:0] res);
    do @(negedge clock); while (!frmReady);
    @(posedge clock);
    deqReq <= 1'b1;
    deqPort <= p;
    @(posedge clock);
    deqReq <= 1'b0;
    do @(negedge clock); while (!deqValid);
    res = {deqEmpty, deqDrop, deqHandle};
    @(posedge clock);
  endtask : popQueue
endmodule : ffw_port_partner

/* File: frame_forwarding_filter_tb_top.sv */
// Self-checking bench: APB configuration, forwarding decisions, queues.
// Assumes ffw_pkg and the port partner model are compiled first.
`timescale 1ns/1ps
module frame_forwarding_filter_tb_top;
  logic clock;
  logic reset_n;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic frmValid, frmReady, frmDstKnown, fwdValid, deqReq;
  logic [4:0] frmSrcPort, frmDstPort, deqPort;
  ffw_pkg::ffw_da_t frmDaClass;
  logic [15:0] frmHandle, fwdHandle, deqHandle;
  logic [23:0] fwdMask, congest, csmaEn, jamReq, pauseReq;
  logic deqValid, deqEmpty, deqDrop;
  logic [24:0] fr;
  logic [17:0] qr;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int tests_run = 0;

  ffw_forward_filter dut_u (.clock, .reset_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .frmValid, .frmReady,
    .frmSrcPort, .frmDaClass, .frmDstKnown, .frmDstPort, .frmHandle,
    .fwdValid, .fwdMask, .fwdHandle, .deqReq, .deqPort, .deqValid,
    .deqEmpty, .deqDrop, .deqHandle, .congest, .csmaEn, .jamReq,
    .pauseReq);

  ffw_port_partner partner_u (.clock, .frmValid, .frmReady, .frmSrcPort,
    .frmDaClass, .frmDstKnown, .frmDstPort, .frmHandle, .fwdValid,
    .fwdMask, .deqReq, .deqPort, .deqValid, .deqEmpty, .deqDrop,
    .deqHandle);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apbXfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    logic ok;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(negedge clock);
      ok = pready;
      rd = prdata;
      err = pslverr;
      @(posedge clock);
    end while (!ok);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apbXfer

  task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
    apbXfer(1'b0, a, 32'h0000_0000);
    check("register", rd, exp);
  endtask : regRd

  task automatic frm(input logic [4:0] s, input ffw_pkg::ffw_da_t c,
      input logic k, input logic [4:0] d, input logic [23:0] exp);
    logic [15:0] h;
    h = 16'h0100 + 16'(tests_run);
    partner_u.sendFrame(s, c, k, d, h, fr);
    check("fwdMask", 32'(fr), {8'h01, exp});
    check("fwdHandle", 32'(fwdHandle), 32'(h));
  endtask : frm

  task automatic pop(input logic [4:0] p, input logic [17:0] exp);
    partner_u.popQueue(p, qr);
    check("dequeue", 32'(qr), 32'(exp));
  endtask : pop

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    congest = 24'h00_0000;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    // ------
    // Register reset values and refusals
    // ------
    regRd(ffw_pkg::ADDR_CFG, 32'h0000_0000);
    regRd(ffw_pkg::ADDR_VLAN0, 32'(ffw_pkg::VLAN0_RST));
    regRd(ffw_pkg::ADDR_FCTRL, ffw_pkg::FCTRL_RST);
    regRd(ffw_pkg::ADDR_BLOCK, 32'h0000_0000);
    apbXfer(1'b1, 8'h40, 32'h0000_ffff);
    check("pslverr", 32'(err), 32'h0000_0001);
    regRd(8'h40, 32'h0000_0000);
    // ------
    // Configuration: VLAN0 ports 0-7 and 23, VLAN1 ports 12-13
    // ------
    apbXfer(1'b1, ffw_pkg::ADDR_VLAN0, 32'h0080_00ff);
    apbXfer(1'b1, ffw_pkg::ADDR_VLAN0 + 8'h04, 32'h0000_3000);
    apbXfer(1'b1, ffw_pkg::ADDR_DUMP, 32'h0000_0d05);
    apbXfer(1'b1, ffw_pkg::ADDR_STPPORT, 32'h0000_000c);
    regRd(ffw_pkg::ADDR_VLAN0, 32'h0080_00ff);
    // ------
    // Decisions with flooding and spanning tree off
    // ------
    frm(5'h02, ffw_pkg::DA_UCAST, 1'b1, 5'h05, 24'h00_0020);
    frm(5'h02, ffw_pkg::DA_BCAST, 1'b0, 5'h00, 24'h80_00fb);
    frm(5'h02, ffw_pkg::DA_UCAST, 1'b0, 5'h00, 24'h00_0020);
    frm(5'h02, ffw_pkg::DA_UCAST, 1'b1, 5'h09, 24'h00_0020);
    frm(5'h02, ffw_pkg::DA_MCAST, 1'b0, 5'h00, 24'h80_00fb);
    // Port 5 queue keeps arrival order, then runs empty
    for (int i = 0; i < 5; i++) begin
      pop(5'h05, {2'b00, 16'h0107 + 16'(i * 2)});
    end
    partner_u.popQueue(5'h05, qr);
    check("deqEmpty", 32'(qr[17]), 32'h0000_0001);
    frm(5'h02, ffw_pkg::DA_BPDU, 1'b0, 5'h00, 24'h80_00fb);
    frm(5'h02, ffw_pkg::DA_PAUSE, 1'b0, 5'h00, 24'h00_0000);
    // ------
    // Flood-all, then spanning tree
    // ------
    apbXfer(1'b1, ffw_pkg::ADDR_CFG, 32'h0000_1000);
    frm(5'h02, ffw_pkg::DA_UCAST, 1'b0, 5'h00, 24'h80_00fb);
    apbXfer(1'b1, ffw_pkg::ADDR_CFG, 32'h0000_0002);
    frm(5'h17, ffw_pkg::DA_BPDU, 1'b0, 5'h00, 24'h00_1000);
    frm(5'h02, ffw_pkg::DA_BPDU, 1'b0, 5'h00, 24'h80_0000);
    frm(5'h0d, ffw_pkg::DA_BPDU, 1'b0, 5'h00, 24'h00_0000);
    frm(5'h0d, ffw_pkg::DA_UCAST, 1'b1, 5'h0c, 24'h00_1000);
    // ------
    // Block-and-listen on ports 2 and 12
    // ------
    apbXfer(1'b1, ffw_pkg::ADDR_BLOCK, 32'h0000_1004);
    regRd(ffw_pkg::ADDR_BLOCK, 32'h0000_1004);
    pop(5'h0c, {2'b00, 16'h011d});
    pop(5'h0c, {2'b01, 16'h0123});
    frm(5'h02, ffw_pkg::DA_BPDU, 1'b0, 5'h00, 24'h80_0000);
    frm(5'h02, ffw_pkg::DA_UCAST, 1'b1, 5'h05, 24'h00_0000);
    regRd(ffw_pkg::ADDR_FRAMES, 32'h0000_000e);
    // ------
    // Duplex modes and flow control
    // ------
    apbXfer(1'b1, ffw_pkg::ADDR_DUPLEX, 32'h0000_0002);
    congest <= 24'h00_0003;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check("csmaEn", 32'(csmaEn), 32'h00ff_fffd);
    check("jamReq", 32'(jamReq), 32'h0000_0001);
    check("pauseReq", 32'(pauseReq), 32'h0000_0002);
    @(posedge clock);
    apbXfer(1'b1, ffw_pkg::ADDR_FCTRL, 32'h0000_0000);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("flow off", 32'(jamReq | pauseReq), 32'h0000_0000);
    tally_and_finish();
  end
endmodule : frame_forwarding_filter_tb_top
